// *** core/cca_core.v ***
`timescale 1ns/1ns
`include "cca_map.vh"
module cca_core (
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [7:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output wire pready,
   output reg pslverr,
   input wire [15:0] ch_pin_in,
   output wire [15:0] ch_pin_out,
   output reg [15:0] ch_pin_oe,
   input wire companion_timer_six_ovf,
   input wire [1:0] ext_count,
   output wire irq
);

   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   // edge qualifier: bit0 rising, bit1 falling
   function edge_hit;
      input [1:0] sel;
      input now;
      input prev;
      begin
         edge_hit = (sel[0] & now & ~prev) | (sel[1] & ~now & prev);
      end
   endfunction

   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   reg [15:0] tctrl_q; // timer control
   reg [15:0] tval_q [0:1]; // timer counts
   reg [15:0] trel_q [0:1]; // reload values
   reg [15:0] istat_q; // sticky event flags
   reg [15:0] imask_q; // interrupt mask
   reg [15:0] val_q [0:15]; // channel capture/compare values
   reg [6:0] ctl_q [0:15]; // channel control
   reg [15:0] fired_q; // single event spent
   reg [15:0] done_q; // once-per-period compare taken
   reg [15:0] pin_q; // pin output latches
   reg [15:0] pin_prev_q; // previous pin samples
   reg [5:0] presc_q; // free running prescaler
   reg [2:0] phase_q; // stagger slot counter
   reg [1:0] ext_prev_q; // previous count input samples
   reg [1:0] upd_q; // timer changed last cycle
   reg [1:0] ovf_q; // timer overflowed last cycle

   reg [1:0] tick; // raw timer clock per timer
   reg [1:0] tick_g; // gated timer clock
   reg [1:0] ovf; // overflow this cycle
   reg [15:0] cap_hit; // capture events
   reg [15:0] cmp_hit; // qualified compare matches
   reg [15:0] toggle; // pin toggles
   reg [15:0] set_pin; // mode 3 set
   reg [15:0] clr_pin; // mode 3 clear
   reg [15:0] tcap [0:15]; // timer value seen by each channel
   integer i;
   integer k;

   wire stagger = tctrl_q[`CCA_TC_STAGGER];
   wire wr = psel & penable & pwrite; // write takes effect in access phase
   wire setup = psel & ~penable; // read data latched at setup
   wire [3:0] cidx = paddr[5:2];
   wire [1:0] page = paddr[7:6];
   wire wr_ctl = wr & (page == `CCA_PAGE_CTL);
   wire wr_val = wr & (page == `CCA_PAGE_VAL);
   wire wr_istat = wr & (paddr == `CCA_OFS_ISTAT);

   assign pready = 1'b1; // zero wait states
   assign ch_pin_out = pin_q;
   assign irq = |(istat_q & imask_q);

   // ------------------------------------------------------------
   // timer clock selection
   // ------------------------------------------------------------
   // staggered operation lets a timer step only in the last slot of
   // eight, trading resolution for a fixed compare schedule
   always @* begin
      for (k = 0; k < 2; k = k + 1) begin
         case (tctrl_q[k*`CCA_TC_STRIDE+`CCA_TC_SEL +: 3])
            `CCA_CLK_DIV1: tick[k] = 1'b1;
            `CCA_CLK_DIV4: tick[k] = &presc_q[1:0];
            `CCA_CLK_DIV16: tick[k] = &presc_q[3:0];
            `CCA_CLK_DIV64: tick[k] = &presc_q;
            `CCA_CLK_T6OVF: tick[k] = companion_timer_six_ovf;
            `CCA_CLK_EXT: tick[k] = ext_count[k] & ~ext_prev_q[k];
            default: tick[k] = 1'b0;
         endcase
         tick_g[k] = tctrl_q[k*`CCA_TC_STRIDE+`CCA_TC_RUN] & tick[k] &
                     (~stagger | (phase_q == `CCA_STAG_LAST));
         ovf[k] = tick_g[k] & (tval_q[k] == `CCA_TMAX);
      end
   end

   // ------------------------------------------------------------
   // time bases
   // ------------------------------------------------------------
   // a software write to a count beats a tick in the same cycle
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tval_q[0] <= `CCA_RST_16;
         tval_q[1] <= `CCA_RST_16;
         trel_q[0] <= `CCA_RST_16;
         trel_q[1] <= `CCA_RST_16;
         tctrl_q <= `CCA_RST_16;
         presc_q <= 6'h00;
         phase_q <= 3'h0;
         ext_prev_q <= 2'b00;
         upd_q <= 2'b00;
         ovf_q <= 2'b00;
      end else begin
         presc_q <= presc_q + 6'h01;
         phase_q <= phase_q + 3'h1;
         ext_prev_q <= ext_count;
         ovf_q <= ovf;
         if (wr && paddr == `CCA_OFS_TCTRL) begin
            tctrl_q <= pwdata[15:0];
         end
         if (wr && paddr == `CCA_OFS_TREL0) begin
            trel_q[0] <= pwdata[15:0];
         end
         if (wr && paddr == `CCA_OFS_TREL1) begin
            trel_q[1] <= pwdata[15:0];
         end
         for (k = 0; k < 2; k = k + 1) begin
            upd_q[k] <= tick_g[k];
            if (wr && paddr == ((k == 0) ? `CCA_OFS_TVAL0 : `CCA_OFS_TVAL1)) begin
               tval_q[k] <= pwdata[15:0];
               upd_q[k] <= 1'b1; // a new count is compared too
            end else if (ovf[k]) begin
               tval_q[k] <= trel_q[k];
            end else if (tick_g[k]) begin
               tval_q[k] <= tval_q[k] + 16'h0001;
            end
         end
      end
   end

   // ------------------------------------------------------------
   // channel event decode
   // ------------------------------------------------------------
   // compares only fire in the cycle after their timer changed, so a
   // count that stands still does not raise a stream of events
   always @* begin
      for (i = 0; i < 16; i = i + 1) begin
         tcap[i] = tval_q[ctl_q[i][`CCA_CC_TSEL]];
         cap_hit[i] = (ctl_q[i][3:1] == `CCA_M_CAP) &&
                      edge_hit(ctl_q[i][5:4], ch_pin_in[i], pin_prev_q[i]);
         cmp_hit[i] = (ctl_q[i][3:1] >= `CCA_M_CMP0) &&
                      (ctl_q[i][3:1] <= `CCA_M_DBL) &&
                      upd_q[ctl_q[i][`CCA_CC_TSEL]] &&
                      (tcap[i] == val_q[i]) &&
                      !(ctl_q[i][`CCA_CC_SINGLE] && fired_q[i]) &&
                      !(((ctl_q[i][3:1] == `CCA_M_CMP2) ||
                         (ctl_q[i][3:1] == `CCA_M_CMP3)) && done_q[i]);
      end
      for (i = 0; i < 16; i = i + 1) begin
         toggle[i] = cmp_hit[i] && ((ctl_q[i][3:1] == `CCA_M_CMP1) ||
                                    (ctl_q[i][3:1] == `CCA_M_DBL));
         if (i < 8) begin
            // upper partner of a double pair toggles the lower pin
            toggle[i] = toggle[i] || ((ctl_q[i][3:1] == `CCA_M_DBL) &&
                                      cmp_hit[i+8]);
         end
         set_pin[i] = cmp_hit[i] && (ctl_q[i][3:1] == `CCA_M_CMP3);
         clr_pin[i] = (ctl_q[i][3:1] == `CCA_M_CMP3) &&
                      ovf_q[ctl_q[i][`CCA_CC_TSEL]];
         // only pin-driving modes take the pin, modes 0 and 2 leave it
         ch_pin_oe[i] = (ctl_q[i][3:1] == `CCA_M_CMP1) ||
                        (ctl_q[i][3:1] == `CCA_M_CMP3) ||
                        (ctl_q[i][3:1] == `CCA_M_DBL);
      end
   end

   // ------------------------------------------------------------
   // channel array
   // ------------------------------------------------------------
   // in each flag the hardware set wins over the clear
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (i = 0; i < 16; i = i + 1) begin
            val_q[i] <= `CCA_RST_16;
            ctl_q[i] <= 7'h00;
         end
         fired_q <= `CCA_RST_16;
         done_q <= `CCA_RST_16;
         pin_q <= `CCA_RST_16;
         pin_prev_q <= `CCA_RST_16;
      end else begin
         pin_prev_q <= ch_pin_in;
         for (i = 0; i < 16; i = i + 1) begin
            // capture wins over a software write to the same channel
            if (cap_hit[i]) begin
               val_q[i] <= tcap[i];
            end else if (wr_val && cidx == i) begin
               val_q[i] <= pwdata[15:0];
            end
            if (wr_ctl && cidx == i) begin
               ctl_q[i] <= pwdata[6:0];
            end
            // writing the control register re-arms a single event
            if (cmp_hit[i] && ctl_q[i][`CCA_CC_SINGLE]) begin
               fired_q[i] <= 1'b1;
            end else if (wr_ctl && cidx == i) begin
               fired_q[i] <= 1'b0;
            end
            // once-per-period modes rearm at their timer overflow
            if (cmp_hit[i] && ((ctl_q[i][3:1] == `CCA_M_CMP2) ||
                               (ctl_q[i][3:1] == `CCA_M_CMP3))) begin
               done_q[i] <= 1'b1;
            end else if (ovf_q[ctl_q[i][`CCA_CC_TSEL]]) begin
               done_q[i] <= 1'b0;
            end
            // match beats overflow when both land together
            if (toggle[i]) begin
               pin_q[i] <= ~pin_q[i];
            end else if (set_pin[i]) begin
               pin_q[i] <= 1'b1;
            end else if (clr_pin[i]) begin
               pin_q[i] <= 1'b0;
            end
         end
      end
   end

   // ------------------------------------------------------------
   // interrupt status and mask
   // ------------------------------------------------------------
   // captures and every qualified match, mode 0 included, raise a flag
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         istat_q <= `CCA_RST_16;
         imask_q <= `CCA_RST_16;
      end else begin
         istat_q <= (istat_q & ~(wr_istat ? pwdata[15:0] : `CCA_RST_16)) |
                    cap_hit | cmp_hit;
         if (wr && paddr == `CCA_OFS_IMASK) begin
            imask_q <= pwdata[15:0];
         end
      end
   end

   // ------------------------------------------------------------
   // apb read and error
   // ------------------------------------------------------------
   // read data is latched in the setup cycle so the access phase can
   // complete at once; state seen is that of the setup edge
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= `CCA_RST_32;
         pslverr <= 1'b0;
      end else if (setup) begin
         prdata <= `CCA_RST_32;
         pslverr <= 1'b0;
         if (page == `CCA_PAGE_VAL) begin
            prdata <= {16'h0000, val_q[cidx]};
         end else if (page == `CCA_PAGE_CTL) begin
            prdata <= {23'h000000, pin_q[cidx], fired_q[cidx], ctl_q[cidx]};
         end else begin
            case (paddr)
               `CCA_OFS_TCTRL: prdata <= {16'h0000, tctrl_q};
               `CCA_OFS_TVAL0: prdata <= {16'h0000, tval_q[0]};
               `CCA_OFS_TVAL1: prdata <= {16'h0000, tval_q[1]};
               `CCA_OFS_TREL0: prdata <= {16'h0000, trel_q[0]};
               `CCA_OFS_TREL1: prdata <= {16'h0000, trel_q[1]};
               `CCA_OFS_ISTAT: prdata <= {16'h0000, istat_q};
               `CCA_OFS_IMASK: prdata <= {16'h0000, imask_q};
               default: pslverr <= 1'b1; // unmapped, reads zero
            endcase
         end
      end
   end

endmodule // cca_core

// *** include/cca_map.vh ***
`ifndef CCA_MAP_VH
`define CCA_MAP_VH
// ------------------------------------------------------------
// register byte offsets
// ------------------------------------------------------------
`define CCA_OFS_TCTRL 8'h00
`define CCA_OFS_TVAL0 8'h04
`define CCA_OFS_TVAL1 8'h08
`define CCA_OFS_TREL0 8'h0C
`define CCA_OFS_TREL1 8'h10
`define CCA_OFS_ISTAT 8'h14
`define CCA_OFS_IMASK 8'h18
`define CCA_PAGE_VAL 2'h1
`define CCA_PAGE_CTL 2'h2
// ------------------------------------------------------------
// timer control fields, timer k at bit k*8
// ------------------------------------------------------------
`define CCA_TC_STRIDE 8
`define CCA_TC_RUN 0
`define CCA_TC_SEL 1
`define CCA_TC_STAGGER 15
`define CCA_CLK_DIV1 3'h0
`define CCA_CLK_DIV4 3'h1
`define CCA_CLK_DIV16 3'h2
`define CCA_CLK_DIV64 3'h3
`define CCA_CLK_T6OVF 3'h4
`define CCA_CLK_EXT 3'h5
// ------------------------------------------------------------
// channel control fields and modes
// ------------------------------------------------------------
`define CCA_CC_TSEL 0
`define CCA_CC_SINGLE 6
`define CCA_CC_FIRED 7
`define CCA_CC_PIN 8
`define CCA_M_OFF 3'h0
`define CCA_M_CAP 3'h1
`define CCA_M_CMP0 3'h2
`define CCA_M_CMP1 3'h3
`define CCA_M_CMP2 3'h4
`define CCA_M_CMP3 3'h5
`define CCA_M_DBL 3'h6
// ------------------------------------------------------------
// reset values and constants
// ------------------------------------------------------------
`define CCA_RST_16 16'h0000
`define CCA_RST_32 32'h0000_0000
`define CCA_TMAX 16'hFFFF
`define CCA_STAG_LAST 3'h7
`endif

// *** tb/cca_core_assertions.sv ***
`timescale 1ns/1ns
module cca_core_assertions (
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [7:0] paddr,
   input wire [31:0] pwdata,
   input wire [31:0] prdata,
   input wire pready,
   input wire pslverr,
   input wire [15:0] ch_pin_in,
   input wire [15:0] ch_pin_out,
   input wire [15:0] ch_pin_oe,
   input wire companion_timer_six_ovf,
   input wire [1:0] ext_count,
   input wire irq
);
   // ---
   // bus phase helpers
   // ---
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   wire setup_w = psel && !penable;
   wire wr_acc_w = psel && penable && pwrite;
   ready_const_a: assert property (pready) else $error("pready low");
   unmapped_err_a: assert property (setup_w && paddr[7:6] == 2'b11 |=> pslverr)
      else $error("no error on unmapped address");
   mapped_ok_a: assert property (setup_w && paddr[7:6] == 2'b01 |=> !pslverr)
      else $error("error on channel value access");
   unmapped_zero_a: assert property (setup_w && !pwrite && paddr[7:6] == 2'b11
      |=> prdata == 32'h0000_0000) else $error("unmapped read not zero");
   upper_zero_a: assert property (setup_w |=> prdata[31:16] == 16'h0000)
      else $error("upper read bits set");
   rdata_hold_a: assert property (setup_w ##1 1 |=> $stable(prdata))
      else $error("read data moved in access phase");
   // pin drivers follow channel mode only, so they move after a control write
   oe_cause_a: assert property ($changed(ch_pin_oe) |->
      $past(wr_acc_w && paddr[7:6] == 2'b10)) else $error("pin enable moved alone");
   pin_cause_a: assert property ($changed(ch_pin_out) |-> $past(ch_pin_oe) != 16'h0000)
      else $error("pin moved with no output channel");
   mask_off_a: assert property (wr_acc_w && paddr == 8'h18 && pwdata[15:0] == 16'h0000
      |=> !irq) else $error("irq with mask cleared");
   cover property (setup_w && paddr[7:6] == 2'b01);
   cover property ($rose(irq));
   cover property ($changed(ch_pin_out));
endmodule // cca_core_assertions
bind cca_core cca_core_assertions u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .ch_pin_in(ch_pin_in), .ch_pin_out(ch_pin_out),
   .ch_pin_oe(ch_pin_oe), .companion_timer_six_ovf(companion_timer_six_ovf),
   .ext_count(ext_count), .irq(irq));

// *** tb/cca_core_tb_top.sv ***
`timescale 1ns/1ns
module cca_core_tb_top;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [15:0] ext_pins = 16'h0000; // capture sources
   logic six_ovf = 1'b0;
   logic [1:0] ext_cnt = 2'b00;
   wire [31:0] prdata;
   wire pready, pslverr, irq;
   wire [15:0] pin_in, pin_out, pin_oe;
   logic [31:0] rd;
   logic err_seen;
   logic [7:0] ctl_v [2:7] = '{8'h06, 8'h04, 8'h08, 8'h0A, 8'h46, 8'h0C}; // modes per channel
   int err_total = 0;
   int checks_done = 0;
   int cycles = 0;
   initial forever #50 pclk = ~pclk;
   cca_core dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .ch_pin_in(pin_in), .ch_pin_out(pin_out), .ch_pin_oe(pin_oe),
      .companion_timer_six_ovf(six_ovf), .ext_count(ext_cnt), .irq(irq));
   cca_pin_model far (.drive_ext(ext_pins), .pin_out(pin_out), .pin_oe(pin_oe),
      .pin_in(pin_in));
   // ---
   // shared tasks
   // ---
   task automatic end_of_test;
      if (err_total == 0 && checks_done > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   // hang guard: far beyond the 170 or so cycles the sequence needs
   always @(posedge pclk) begin
      cycles++;
      if (cycles == 20000) begin
         err_total++;
         end_of_test();
      end
   end
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         err_total++;
         $display("MISMATCH %s exp %h seen %h", what, exp, seen);
      end
   endtask
   // one transfer; request held until pready is seen high
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rd = prdata;
      err_seen = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rchk(input string what, input logic [7:0] a, input logic [31:0] m,
      input logic [31:0] exp);
      apb(1'b0, a, 32'h0000_0000);
      chk(what, rd & m, exp);
   endtask
   // ---
   // main sequence
   // ---
   initial begin
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      rchk("tctrl", 8'h00, 32'hFFFF_FFFF, 32'h0000_0000);
      rchk("unmapped", 8'hC0, 32'hFFFF_FFFF, 32'h0000_0000);
      chk("slverr", {31'h0, err_seen}, 32'h0000_0001);
      // channels 0..2 capture on rise, fall and both, timer held still
      for (int k = 0; k < 3; k++) apb(1'b1, 8'(8'h80 + 4 * k), 32'(8'h02 | ((k + 1) << 4)));
      apb(1'b1, 8'h04, 32'h0000_1111);
      ext_pins <= 16'h0007;
      repeat (4) @(posedge pclk);
      apb(1'b1, 8'h04, 32'h0000_2222);
      ext_pins <= 16'h0000;
      repeat (4) @(posedge pclk);
      for (int k = 0; k < 3; k++)
         rchk("capture", 8'(8'h40 + 4 * k), 32'h0000_FFFF, k == 0 ? 32'h1111 : 32'h2222);
      rchk("cap flags", 8'h14, 32'h0000_FFFF, 32'h0000_0007);
      apb(1'b1, 8'h18, 32'h0000_0001);
      @(negedge pclk); // let the write edge settle before looking
      chk("irq on", {31'h0, irq}, 32'h0000_0001);
      apb(1'b1, 8'h14, 32'h0000_FFFF);
      @(negedge pclk);
      chk("irq off", {31'h0, irq}, 32'h0000_0000);
      // compare channels 2..7 at 0x10, upper double partner 15 at 0x20
      for (int k = 2; k < 8; k++) apb(1'b1, 8'(8'h40 + 4 * k), 32'h0000_0010);
      apb(1'b1, 8'h7C, 32'h0000_0020);
      for (int k = 2; k < 8; k++) apb(1'b1, 8'(8'h80 + 4 * k), {24'h0, ctl_v[k]});
      apb(1'b1, 8'hBC, 32'h0000_0004);
      @(negedge pclk);
      chk("oe", {16'h0, pin_oe}, 32'h0000_00E4);
      apb(1'b1, 8'h04, 32'h0000_0010);
      repeat (3) @(posedge pclk);
      chk("pins 1", {16'h0, pin_out}, 32'h0000_00E4);
      rchk("flags 1", 8'h14, 32'h0000_0018, 32'h0000_0018);
      apb(1'b1, 8'h14, 32'h0000_FFFF);
      apb(1'b1, 8'h04, 32'h0000_0010);
      repeat (3) @(posedge pclk);
      chk("pins 2", {16'h0, pin_out}, 32'h0000_0060);
      rchk("flags 2", 8'h14, 32'h0000_0018, 32'h0000_0008);
      rchk("fired", 8'h98, 32'h0000_0080, 32'h0000_0080);
      apb(1'b1, 8'h98, 32'h0000_0046);
      apb(1'b1, 8'h04, 32'h0000_0020);
      repeat (3) @(posedge pclk);
      chk("pins 3", {16'h0, pin_out}, 32'h0000_00E0);
      // run timer 0 through overflow into a reload value
      apb(1'b1, 8'h0C, 32'h0000_8000);
      apb(1'b1, 8'h04, 32'h0000_FFFF);
      apb(1'b1, 8'h00, 32'h0000_0001);
      apb(1'b1, 8'h00, 32'h0000_0000);
      repeat (3) @(posedge pclk);
      chk("pins 4", {16'h0, pin_out}, 32'h0000_00C0);
      rchk("reload", 8'h04, 32'h0000_FF00, 32'h0000_8000);
      apb(1'b1, 8'h14, 32'h0000_FFFF);
      apb(1'b1, 8'h04, 32'h0000_0010);
      repeat (3) @(posedge pclk);
      rchk("flags 3", 8'h14, 32'h0000_0010, 32'h0000_0010);
      chk("pins 5", {16'h0, pin_out}, 32'h0000_0024);
      apb(1'b1, 8'h18, 32'h0000_0000);
      end_of_test();
   end
endmodule // cca_core_tb_top

// *** tb/cca_pin_model.sv ***
`timescale 1ns/1ns
// ---
// far side of the sixteen channel pins
// ---
module cca_pin_model (
   input wire logic [15:0] drive_ext,
   input wire logic [15:0] pin_out,
   input wire logic [15:0] pin_oe,
   output logic [15:0] pin_in
);
   // a driven pin reads back the device level, a released one the source
   assign pin_in = (pin_oe & pin_out) | (~pin_oe & drive_ext);
endmodule // cca_pin_model
